// ==== rtl/isa_card.sv ====
`timescale 1ns/10ps
`include "isa_cfg.svh"
module isa_card (
    input  wire logic        i_sys_clk,
    input  wire logic        i_arst_n,
    input  wire logic [6:0]  i_drq,
    input  wire logic [10:0] i_irq,
    input  wire logic        i_nows,
    input  wire logic        i_master_req,
    input  wire logic [2:0]  i_master_idx,
    output logic [6:0]       o_dack,
    output logic             o_tc,
    output logic             o_refresh,
    output logic             o_resetdrv,
    output logic             o_addr_en,
    output logic             o_cmd_en,
    output logic             o_master_own,
    output logic             o_timeout,
    isa_link_if.card         bus
);

    isa_pkg::isa_card_st_t st_reg;
    isa_pkg::isa_card_st_t st_next;
    logic                  rise;

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        st_next          = st_reg;
        st_next.clk_s1   = bus.sysclk;
        st_next.clk_s2   = st_reg.clk_s1;
        st_next.clk_prev = st_reg.clk_s2;
        st_next.dack_s1  = bus.dack_n;
        st_next.dack_s2  = st_reg.dack_s1;
        st_next.ref_s1   = bus.refsh_n;
        st_next.ref_s2   = st_reg.ref_s1;
        st_next.rst_s1   = bus.resetdrv;
        st_next.rst_s2   = st_reg.rst_s1;
        st_next.tc_s1    = bus.tc;
        st_next.tc_s2    = st_reg.tc_s1;
        rise             = st_reg.clk_s2 & ~st_reg.clk_prev;
        st_next.irq      = i_irq;
        st_next.nows_oe  = i_nows;
        st_next.drq      = i_drq;
        if (st_reg.ms != isa_pkg::MS_IDLE && st_reg.ms != isa_pkg::MS_DONE) begin
            st_next.drq[st_reg.ch] = 1'b1;
        end
        if (st_reg.master_oe) begin
            st_next.mcnt = st_reg.mcnt + 11'h001;
        end

        case (st_reg.ms)
            isa_pkg::MS_IDLE: begin
                if (i_master_req) begin
                    st_next.ch      = i_master_idx;
                    st_next.timeout = 1'b0;
                    st_next.ms      = isa_pkg::MS_REQ;
                end
            end
            isa_pkg::MS_REQ: begin
                if (!st_reg.dack_s2[st_reg.ch] && rise) begin
                    st_next.master_oe = 1'b1;
                    st_next.mcnt      = 11'h000;
                    st_next.ms        = isa_pkg::MS_ADDR;
                end else if (!i_master_req) begin
                    st_next.ms = isa_pkg::MS_IDLE;
                end
            end
            isa_pkg::MS_ADDR: begin
                if (rise) begin
                    st_next.addr_en = 1'b1;
                    st_next.ms      = isa_pkg::MS_CMD;
                end
            end
            isa_pkg::MS_CMD: begin
                if (rise) begin
                    st_next.cmd_en = 1'b1;
                    st_next.ms     = isa_pkg::MS_OWN;
                end
            end
            isa_pkg::MS_OWN: begin
                if (!i_master_req || st_reg.mcnt >= 11'(`ISA_MST_LIMIT_CYC - 10)) begin
                    st_next.timeout   = i_master_req;
                    st_next.master_oe = 1'b0;
                    st_next.addr_en   = 1'b0;
                    st_next.cmd_en    = 1'b0;
                    st_next.ms        = isa_pkg::MS_DONE;
                end
            end
            isa_pkg::MS_DONE: begin
                if (!i_master_req) begin
                    st_next.ms = isa_pkg::MS_IDLE;
                end
            end
            default: st_next.ms = isa_pkg::MS_IDLE;
        endcase
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg         <= '0;
            st_reg.dack_s1 <= 7'h7F;
            st_reg.dack_s2 <= 7'h7F;
            st_reg.ref_s1  <= 1'b1;
            st_reg.ref_s2  <= 1'b1;
            st_reg.ms      <= isa_pkg::MS_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.drq       = st_reg.drq;
    assign bus.irq       = st_reg.irq;
    assign bus.nows_o    = 1'b0;
    assign bus.nows_oe   = st_reg.nows_oe;
    assign bus.master_o  = 1'b0;
    assign bus.master_oe = st_reg.master_oe;
    assign o_dack        = ~st_reg.dack_s2;
    assign o_tc          = st_reg.tc_s2;
    assign o_refresh     = ~st_reg.ref_s2;
    assign o_resetdrv    = st_reg.rst_s2;
    assign o_addr_en     = st_reg.addr_en;
    assign o_cmd_en      = st_reg.cmd_en;
    assign o_master_own  = st_reg.master_oe;
    assign o_timeout     = st_reg.timeout;

endmodule : isa_card

// ==== rtl/isa_cfg.svh ====
`ifndef ISA_CFG_SVH
`define ISA_CFG_SVH
`define ISA_NUM_DMA        7
`define ISA_NUM_IRQ        11
`define ISA_SYS_PERIOD_NS  10
`define ISA_SYSCLK_DIV     12
`define ISA_SYSCLK_HIGH    6
`define ISA_OSC_DIV        7
`define ISA_OSC_HIGH       3
`define ISA_REF_PERIOD_NS  15600
`define ISA_REF_CYC        (`ISA_REF_PERIOD_NS / `ISA_SYS_PERIOD_NS)
`define ISA_REF_LOW_CYC    12
`define ISA_WS_8BIT        4
`define ISA_WS_16BIT       1
`define ISA_RSTDRV_CYC     100
`define ISA_MST_LIMIT_NS   15000
`define ISA_MST_LIMIT_CYC  (`ISA_MST_LIMIT_NS / `ISA_SYS_PERIOD_NS)
`endif

// ==== rtl/isa_host.sv ====
`timescale 1ns/10ps
`include "isa_cfg.svh"
module isa_host (
    input  wire logic       i_sys_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_sleep,
    input  wire logic       i_cyc_req,
    input  wire logic       i_cyc_16,
    input  wire logic [6:0] i_cascade,
    input  wire logic [7:0] i_dma_len,
    input  wire logic       i_irq_ack,
    output logic            o_cyc_busy,
    output logic            o_cyc_done,
    output logic            o_dma_active,
    output logic [2:0]      o_dma_chan,
    output logic            o_irq_valid,
    output logic [3:0]      o_irq_num,
    output logic            o_refresh,
    isa_link_if.host        bus
);

    isa_pkg::isa_host_st_t st_reg;
    isa_pkg::isa_host_st_t st_next;

    // --------------------------------------------------------------
    // Decoding helpers
    // --------------------------------------------------------------
    // Line number of each request bit: 3..7, 9..12, 14, 15.
    function automatic logic [3:0] irq_line(input logic [3:0] idx);
        logic [3:0] l;
        if (idx < 4'h5) begin
            l = idx + 4'h3;
        end else if (idx < 4'h9) begin
            l = idx + 4'h4;
        end else begin
            l = idx + 4'h5;
        end
        return l;
    endfunction : irq_line

    // Channel number of each request bit: 0..3, 5..7.
    function automatic logic [2:0] dma_chan(input logic [2:0] idx);
        return (idx < 3'h4) ? idx : idx + 3'h1;
    endfunction : dma_chan

    // Lowest set bit wins; channel 0 has top priority.
    function automatic logic [2:0] dma_pick(input logic [6:0] r);
        logic [2:0] p;
        p = 3'h0;
        for (int i = 6; i >= 0; i--) begin
            if (r[i]) begin
                p = 3'(i);
            end
        end
        return p;
    endfunction : dma_pick

    logic       tick;
    logic [3:0] ipick;
    logic       ifound;

    always_comb begin
        ipick  = 4'h0;
        ifound = 1'b0;
        for (int i = 4; i >= 0; i--) begin
            if (st_reg.pend[i]) begin
                ipick  = 4'(i);
                ifound = 1'b1;
            end
        end
        for (int i = 10; i >= 5; i--) begin
            if (st_reg.pend[i]) begin
                ipick  = 4'(i);
                ifound = 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        st_next  = st_reg;
        tick     = (st_reg.div == 4'(`ISA_SYSCLK_DIV - 1));
        st_next.cyc_done = 1'b0;

        if (i_sleep) begin
            st_next.div    = 4'h0;
            st_next.sysclk = 1'b0;
        end else begin
            st_next.div    = tick ? 4'h0 : st_reg.div + 4'h1;
            st_next.sysclk = (st_next.div < 4'(`ISA_SYSCLK_HIGH));
        end
        if (i_sleep) begin
            st_next.osc_cnt = 3'h0;
            st_next.osc     = 1'b0;
        end else begin
            st_next.osc_cnt = (st_reg.osc_cnt == 3'(`ISA_OSC_DIV - 1)) ? 3'h0
                              : st_reg.osc_cnt + 3'h1;
            st_next.osc     = (st_next.osc_cnt < 3'(`ISA_OSC_HIGH));
        end

        if (st_reg.rst_cnt != 8'(`ISA_RSTDRV_CYC)) begin
            st_next.rst_cnt = st_reg.rst_cnt + 8'h01;
        end else begin
            st_next.resetdrv = 1'b0;
        end

        st_next.drq_s1  = bus.drq;
        st_next.drq_s2  = st_reg.drq_s1;
        st_next.irq_s1  = bus.irq;
        st_next.irq_s2  = st_reg.irq_s1;
        st_next.nows_s1 = bus.nows_n;
        st_next.nows_s2 = st_reg.nows_s1;
        st_next.mst_s1  = bus.master_n;
        st_next.mst_s2  = st_reg.mst_s1;

        if (st_reg.ref_cnt == 11'(`ISA_REF_CYC - 1)) begin
            st_next.ref_cnt  = 11'h000;
            st_next.ref_pend = 1'b1;
        end else begin
            st_next.ref_cnt = st_reg.ref_cnt + 11'h001;
        end
        // no refresh while master owns bus
        if (st_reg.refsh_n && st_reg.ref_pend && st_reg.mst_s2) begin
            st_next.ref_pend = 1'b0;
            st_next.refsh_n  = 1'b0;
            st_next.ref_low  = 4'h0;
        end else if (!st_reg.refsh_n) begin
            st_next.ref_low = st_reg.ref_low + 4'h1;
            if (st_reg.ref_low == 4'(`ISA_REF_LOW_CYC - 1)) begin
                st_next.refsh_n = 1'b1;
            end
        end

        case (st_reg.cyc)
            isa_pkg::CYC_IDLE: begin
                if (i_cyc_req) begin
                    st_next.cyc = isa_pkg::CYC_RUN;
                    st_next.ws  = i_cyc_16 ? 3'(`ISA_WS_16BIT) : 3'(`ISA_WS_8BIT);
                end
            end
            isa_pkg::CYC_RUN: begin
                if (tick) begin
                    if (st_reg.ws == 3'h0 || !st_reg.nows_s2) begin
                        st_next.cyc      = isa_pkg::CYC_IDLE;
                        st_next.cyc_done = 1'b1;
                    end else begin
                        st_next.ws = st_reg.ws - 3'h1;
                    end
                end
            end
            default: st_next.cyc = isa_pkg::CYC_IDLE;
        endcase

        st_next.irq_prev = st_reg.irq_s2;
        st_next.pend     = st_reg.pend | (st_reg.irq_s2 & ~st_reg.irq_prev);
        for (int i = 0; i < 11; i++) begin
            if (i_irq_ack && st_reg.irq_valid && irq_line(4'(i)) == st_reg.irq_num) begin
                st_next.pend[i] = st_reg.irq_s2[i] & ~st_reg.irq_prev[i];
            end
        end
        st_next.irq_valid = ifound;
        st_next.irq_num   = irq_line(ipick);

        case (st_reg.dma)
            isa_pkg::DMA_IDLE: begin
                st_next.aen = 1'b0;
                st_next.tc  = 1'b0;
                if (st_reg.drq_s2 != 7'h00 && st_reg.refsh_n && tick) begin
                    st_next.dma_idx = dma_pick(st_reg.drq_s2);
                    st_next.dack_n = ~(7'h01 << dma_pick(st_reg.drq_s2));
                    st_next.dma_cnt = i_dma_len;
                    if (i_cascade[dma_pick(st_reg.drq_s2)]) begin
                        st_next.dma = isa_pkg::DMA_CASC;
                    end else begin
                        st_next.aen = 1'b1;
                        st_next.tc  = (i_dma_len == 8'h00);
                        st_next.dma = isa_pkg::DMA_XFER;
                    end
                end
            end
            isa_pkg::DMA_XFER: begin
                if (tick) begin
                    if (st_reg.dma_cnt == 8'h00) begin
                        st_next.dma    = isa_pkg::DMA_IDLE;
                        st_next.dack_n = 7'h7F;
                        st_next.aen    = 1'b0;
                        st_next.tc     = 1'b0;
                    end else begin
                        st_next.dma_cnt = st_reg.dma_cnt - 8'h01;
                        st_next.tc      = (st_reg.dma_cnt == 8'h01);
                    end
                end
            end
            isa_pkg::DMA_CASC: begin
                if (!st_reg.drq_s2[st_reg.dma_idx] && st_reg.mst_s2) begin
                    st_next.dma    = isa_pkg::DMA_IDLE;
                    st_next.dack_n = 7'h7F;
                end
            end
            default: st_next.dma = isa_pkg::DMA_IDLE;
        endcase
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg          <= '0;
            st_reg.resetdrv <= 1'b1;
            st_reg.refsh_n  <= 1'b1;
            st_reg.nows_s1  <= 1'b1;
            st_reg.nows_s2  <= 1'b1;
            st_reg.mst_s1   <= 1'b1;
            st_reg.mst_s2   <= 1'b1;
            st_reg.dack_n   <= 7'h7F;
            st_reg.cyc      <= isa_pkg::CYC_IDLE;
            st_reg.dma      <= isa_pkg::DMA_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.dack_n   = st_reg.dack_n;
    assign bus.refsh_n  = st_reg.refsh_n;
    assign bus.sysclk   = st_reg.sysclk;
    assign bus.osc      = st_reg.osc;
    assign bus.resetdrv = st_reg.resetdrv;
    assign bus.aen      = st_reg.aen;
    assign bus.tc       = st_reg.tc;
    assign o_cyc_busy   = (st_reg.cyc == isa_pkg::CYC_RUN);
    assign o_cyc_done   = st_reg.cyc_done;
    assign o_dma_active = (st_reg.dma != isa_pkg::DMA_IDLE);
    assign o_dma_chan   = dma_chan(st_reg.dma_idx);
    assign o_irq_valid  = st_reg.irq_valid;
    assign o_irq_num    = st_reg.irq_num;
    assign o_refresh    = ~st_reg.refsh_n;

endmodule : isa_host

// ==== rtl/isa_link_if.sv ====
`timescale 1ns/10ps
interface isa_link_if;
    logic       refsh_n;
    logic       sysclk;
    logic       osc;
    logic       resetdrv;
    logic       aen;
    logic       tc;
    logic [6:0] dack_n;
    logic [6:0] drq;
    logic [10:0] irq;
    logic       nows_o;
    logic       nows_oe;
    logic       nows_n;
    logic       master_o;
    logic       master_oe;
    logic       master_n;

    // Open-drain lines with pull-up.
    assign nows_n   = nows_oe ? nows_o : 1'b1;
    assign master_n = master_oe ? master_o : 1'b1;

    modport host (
        output refsh_n, sysclk, osc, resetdrv, aen, tc, dack_n,
        input  drq, irq, nows_n, master_n
    );
    modport card (
        input  refsh_n, sysclk, osc, resetdrv, aen, tc, dack_n, nows_n, master_n,
        output drq, irq, nows_o, nows_oe, master_o, master_oe
    );
endinterface : isa_link_if

// ==== rtl/isa_pkg.sv ====
package isa_pkg;
    typedef enum logic [1:0] {CYC_IDLE, CYC_RUN} isa_cyc_t;
    typedef enum logic [1:0] {DMA_IDLE, DMA_XFER, DMA_CASC} isa_dma_t;
    typedef enum logic [2:0] {MS_IDLE, MS_REQ, MS_ADDR, MS_CMD, MS_OWN, MS_DONE} isa_ms_t;

    typedef struct packed {
        logic [3:0]  div;
        logic        sysclk;
        logic [2:0]  osc_cnt;
        logic        osc;
        logic [7:0]  rst_cnt;
        logic        resetdrv;
        logic [10:0] ref_cnt;
        logic        ref_pend;
        logic [3:0]  ref_low;
        logic        refsh_n;
        isa_cyc_t    cyc;
        logic [2:0]  ws;
        logic        cyc_done;
        logic [6:0]  drq_s1;
        logic [6:0]  drq_s2;
        logic [10:0] irq_s1;
        logic [10:0] irq_s2;
        logic [10:0] irq_prev;
        logic [10:0] pend;
        logic [3:0]  irq_num;
        logic        irq_valid;
        logic        nows_s1;
        logic        nows_s2;
        logic        mst_s1;
        logic        mst_s2;
        isa_dma_t    dma;
        logic [2:0]  dma_idx;
        logic [6:0]  dack_n;
        logic        aen;
        logic        tc;
        logic [7:0]  dma_cnt;
    } isa_host_st_t;

    typedef struct packed {
        logic        clk_s1;
        logic        clk_s2;
        logic        clk_prev;
        logic [6:0]  dack_s1;
        logic [6:0]  dack_s2;
        logic        ref_s1;
        logic        ref_s2;
        logic        rst_s1;
        logic        rst_s2;
        logic        tc_s1;
        logic        tc_s2;
        isa_ms_t     ms;
        logic [2:0]  ch;
        logic [10:0] mcnt;
        logic        master_oe;
        logic        addr_en;
        logic        cmd_en;
        logic        timeout;
        logic [6:0]  drq;
        logic [10:0] irq;
        logic        nows_oe;
    } isa_card_st_t;
endpackage : isa_pkg

// ==== sim/isa_bus_dma_irq_master_tb.sv ====
`timescale 1ns/10ps
// ----
// Bench for host and card.
// ----
module isa_bus_dma_irq_master_tb;
    logic        i_sys_clk = 1'b0;
    logic        i_arst_n  = 1'b0;
    logic        slp = 1'b0, req = 1'b0, w16 = 1'b0, ack = 1'b0, nws = 1'b0, mrq = 1'b0;
    logic [6:0]  casc = 7'h00, drq = 7'h00;
    logic [7:0]  len = 8'h02;
    logic [10:0] irq = 11'h000;
    logic [2:0]  midx = 3'h0, chan;
    logic [3:0]  inum;
    logic        done, ivld, own, adr, cmd, tmo;
    logic        busy, dact, hrf, crf, ctc, crd;
    logic [6:0]  cdk;
    int          err_total = 0, checked = 0, cyc = 0, n, p, t;
    isa_link_if link ();
    isa_host u_isa_host (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_sleep(slp),
        .i_cyc_req(req), .i_cyc_16(w16), .i_cascade(casc), .i_dma_len(len), .i_irq_ack(ack),
        .o_cyc_busy(busy), .o_cyc_done(done), .o_dma_active(dact), .o_dma_chan(chan),
        .o_irq_valid(ivld), .o_irq_num(inum), .o_refresh(hrf), .bus(link));
    isa_card u_isa_card (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_drq(drq),
        .i_irq(irq), .i_nows(nws), .i_master_req(mrq), .i_master_idx(midx), .o_dack(cdk),
        .o_tc(ctc), .o_refresh(crf), .o_resetdrv(crd), .o_addr_en(adr), .o_cmd_en(cmd),
        .o_master_own(own), .o_timeout(tmo), .bus(link));
    isa_link_sva u_isa_link_sva (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
        .refsh_n(link.refsh_n), .sysclk(link.sysclk), .osc(link.osc),
        .resetdrv(link.resetdrv), .aen(link.aen), .tc(link.tc), .dack_n(link.dack_n),
        .drq(link.drq), .master_n(link.master_n));
    always #5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic t_cyc(input logic wide, input logic nw, input int lo, input int hi);
        @(negedge i_sys_clk);
        w16 = wide;
        nws = nw;
        req = 1'b1;
        @(negedge i_sys_clk);
        req = 1'b0;
        chk(busy === 1'b1, "bus cycle busy");
        for (n = 1; n < 100 && done !== 1'b1; n++) @(negedge i_sys_clk);
        nws = 1'b0;
        chk(n >= lo && n <= hi && busy === 1'b0, "bus cycle length");
        $display("bus cycle test done");
    endtask : t_cyc
    task automatic t_refresh();
        for (n = 0; n < 2000 && link.refsh_n !== 1'b0; n++) @(negedge i_sys_clk);
        for (n = 0; n < 40 && link.refsh_n === 1'b0; n++) @(negedge i_sys_clk);
        chk(n == 12 && hrf === 1'b0 && crf === 1'b1, "refresh strobe length");
        for (p = n; p < 2000 && link.refsh_n !== 1'b0; p++) @(negedge i_sys_clk);
        chk(p >= 1559 && p <= 1561, "refresh period");
        $display("refresh test done");
    endtask : t_refresh
    task automatic t_dma();
        logic [2:0] map [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
        for (int k = 0; k < 7; k++) begin
            @(negedge i_sys_clk);
            drq = 7'h01 << k;
            for (n = 0; n < 200 && link.dack_n !== ~drq; n++) @(negedge i_sys_clk);
            chk(link.dack_n === ~drq && link.aen === 1'b1 && dact === 1'b1, "dma grant");
            chk(chan === map[k], "dma channel number");
            drq = 7'h00;
            t = 0;
            for (n = 0; n < 80 && link.aen === 1'b1; n++) begin
                t += (link.tc === 1'b1);
                @(negedge i_sys_clk);
            end
            chk(n >= 34 && n <= 36 && t >= 11 && t <= 12, "dma count");
            chk(link.dack_n === 7'h7F && !link.tc && ctc === 1'b1, "dma release");
        end
        $display("dma test done");
    endtask : t_dma
    task automatic t_master();
        @(negedge i_sys_clk);
        casc = 7'h20;
        midx = 3'h5;
        mrq = 1'b1;
        for (n = 0; n < 300 && own !== 1'b1; n++) @(negedge i_sys_clk);
        chk(link.master_n === 1'b0 && link.dack_n === 7'h5F && !link.aen && cdk === 7'h20,
            "takeover");
        for (p = 0; p < 40 && adr !== 1'b1; p++) @(negedge i_sys_clk);
        for (t = p; t < 40 && cmd !== 1'b1; t++) @(negedge i_sys_clk);
        chk(p >= 8 && t >= p + 10 && t < 40, "master drive delays");
        t = 0;
        for (n = p; n < 2000 && link.master_n === 1'b0; n++) begin
            t += (link.refsh_n === 1'b0 && n > 20);
            @(negedge i_sys_clk);
        end
        chk(t == 0 && tmo === 1'b1 && n >= 1400 && n <= 1500, "master hold");
        mrq = 1'b0;
        for (n = 0; n < 200 && link.dack_n !== 7'h7F; n++) @(negedge i_sys_clk);
        chk(link.dack_n === 7'h7F, "cascade release");
        casc = 7'h00;
        $display("master test done");
    endtask : t_master
    task automatic t_irq();
        logic [3:0] ord [11] = '{4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
        for (int k = 0; k < 12; k++) begin
            @(negedge i_sys_clk);
            irq = (k < 11) ? 11'h7FF : 11'h010;
            for (n = 0; n < 20 && ivld !== 1'b1; n++) @(negedge i_sys_clk);
            chk(ivld === 1'b1 && inum === ord[k % 11 + k / 11 * 10], "irq order");
            ack = 1'b1;
            @(negedge i_sys_clk);
            ack = 1'b0;
            repeat (3) @(negedge i_sys_clk);
            if (k == 10) begin
                chk(ivld === 1'b0, "held line does not retrigger");
                irq = 11'h000;
                repeat (4) @(negedge i_sys_clk);
            end
        end
        irq = 11'h000;
        $display("irq test done");
    endtask : t_irq
    task automatic t_clocks();
        for (int s = 0; s < 2; s++) begin
            @(negedge i_sys_clk);
            slp = s[0];
            repeat (4) @(negedge i_sys_clk);
            p = 0;
            t = 0;
            for (n = 0; n < 84; n++) begin
                p += (link.sysclk === 1'b1);
                t += (link.osc === 1'b1);
                @(negedge i_sys_clk);
            end
            chk(p == (s ? 0 : 42), "bus clock duty");
            chk(t == (s ? 0 : 36), "oscillator duty");
        end
        slp = 1'b0;
        $display("clock test done");
    endtask : t_clocks
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (16) @(negedge i_sys_clk);
        i_arst_n = 1'b1;
        chk(link.resetdrv === 1'b1 && link.dack_n === 7'h7F, "reset levels");
        for (n = 0; n < 300 && link.resetdrv !== 1'b0; n++) @(negedge i_sys_clk);
        chk(n >= 95 && n <= 101 && crd === 1'b1, "reset drive length");
        t_cyc(1'b0, 1'b0, 50, 61);
        t_cyc(1'b1, 1'b0, 14, 25);
        t_cyc(1'b0, 1'b1, 2, 26);
        t_refresh();
        t_dma();
        t_master();
        t_irq();
        t_clocks();
        print_verdict();
    end
endmodule : isa_bus_dma_irq_master_tb

// ==== sim/isa_link_sva.sv ====
`timescale 1ns/10ps
// ----
// Link checker.
// ----
module isa_link_sva (
    input wire logic       i_sys_clk,
    input wire logic       i_arst_n,
    input wire logic       refsh_n,
    input wire logic       sysclk,
    input wire logic       osc,
    input wire logic       resetdrv,
    input wire logic       aen,
    input wire logic       tc,
    input wire logic [6:0] dack_n,
    input wire logic [6:0] drq,
    input wire logic       master_n
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);
    logic [11:0] gap_reg;
    logic [1:0]  skip_reg;
    // Refreshes deferred by a bus master and the next one leave the fixed grid.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            skip_reg <= 2'h0;
        end else if (!master_n) begin
            skip_reg <= 2'h2;
        end else if ($fell(refsh_n) && skip_reg != 2'h0) begin
            skip_reg <= skip_reg - 2'h1;
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gap_reg <= 12'h000;
        end else if (!refsh_n) begin
            gap_reg <= 12'h000;
        end else if (gap_reg != 12'hFFF) begin
            gap_reg <= gap_reg + 12'h001;
        end
    end
    AST_REF_GAP: assert property ($fell(refsh_n) && skip_reg == 2'h0
        |-> gap_reg >= 12'h604)
        else $error("refresh started too early");
    AST_REF_LOW: assert property ($fell(refsh_n) |-> (!refsh_n)[*8])
        else $error("refresh strobe too short");
    AST_REF_MST: assert property ((!master_n)[*5] |-> !$fell(refsh_n))
        else $error("refresh while master owns bus");
    AST_RST_HOLD: assert property ($rose(i_arst_n) |-> resetdrv[*8])
        else $error("reset drive released early");
    AST_DACK_ONE: assert property ($onehot0(~dack_n))
        else $error("more than one acknowledge");
    AST_TC_DMA: assert property (tc |-> aen && dack_n != 7'h7F)
        else $error("terminal count outside transfer");
    AST_AEN_ACK: assert property (aen |-> dack_n != 7'h7F)
        else $error("address enable without acknowledge");
    AST_DACK_REQ: assert property ($past(dack_n) == 7'h7F && dack_n != 7'h7F
        |-> ($past(drq, 3) & ~dack_n) != 7'h00)
        else $error("grant without synced request");
    AST_MST_ACK: assert property ($fell(master_n) |-> dack_n != 7'h7F)
        else $error("master without acknowledge");
    AST_BCLK_HI: assert property ($rose(sysclk) |-> ##6 !sysclk)
        else $error("bus clock high too long");
    AST_OSC_HI: assert property ($rose(osc) |-> ##3 !osc)
        else $error("oscillator high too long");
    cover property ($fell(refsh_n));
    cover property ($rose(tc));
    cover property ($fell(master_n));
    cover property ($fell(dack_n[6]));
endmodule : isa_link_sva
